/* File: verilog/mds_pkg.sv */
/*
 * Package of the multichip sync block: register indices, field positions,
 * reset values, mode codes and FIFO geometry.
 * Assumes a 32-bit AXI4-Lite register bus, one word per register index.
 */
package mds_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_SYNC_CTRL = 8'h10;
    localparam logic [7:0] IDX_SYNC_STAT = 8'h12;
    localparam logic [7:0] IDX_CLK_DLY   = 8'h16;
    localparam logic [7:0] IDX_IRQ_STAT  = 8'h20;
    localparam logic [7:0] IDX_IRQ_MASK  = 8'h21;
    localparam logic [7:0] IDX_CLK_CFG   = 8'h22;
    localparam int         ADDR_W        = 12;

    // ------------------------------------------------------------
    // Fields and values
    // ------------------------------------------------------------
    localparam int         CTRL_EN_BIT    = 7;
    localparam int         CTRL_DRATE_BIT = 6;
    localparam int         CTRL_PER_BIT   = 3;
    localparam int         STAT_LOCK_BIT  = 6;
    localparam int         CFG_MULT_BIT   = 0;
    localparam logic [7:0] MODE_DATA_RATE = 8'hc8;
    localparam logic [7:0] MODE_FIFO_RATE = 8'h88;
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [1:0] DLY_RESET      = 2'h0;
    localparam logic [2:0] IRQ_RESET      = 3'h0;
    localparam int         IRQ_W          = 3;
    localparam int         IRQ_LOCK_BIT   = 0;
    localparam int         IRQ_UNLOCK_BIT = 1;
    localparam int         IRQ_FRAME_BIT  = 2;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

    // ------------------------------------------------------------
    // FIFO and lock
    // ------------------------------------------------------------
    localparam int         FIFO_DEPTH = 8;
    localparam int         PTR_W      = 3;
    localparam int         DATA_W     = 16;
    localparam logic [2:0] RD_OFFSET  = 3'h4;
    localparam logic [2:0] PHASE_LAST = 3'h7;
    localparam logic [1:0] LOCK_EDGES = 2'h2;
    localparam int         DLY_TAPS   = 4;

    typedef enum logic [1:0] {ST_OFF, ST_ACQ, ST_LOCK} mds_lock_t;

endpackage : mds_pkg

/* File: verilog/mds_sync.sv */
/*
 * Two-flop synchroniser with rising-edge detect, W bits wide.
 * Assumes inputs are asynchronous to clk; edge detect reads only stage two.
 */
`timescale 1ns/1ps
module mds_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q,
    output logic      [W-1:0] rise
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;
    logic [W-1:0] prev_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q_ff    <= '0;
            prev_ff <= '0;
        end else begin
            meta_ff <= d;
            q_ff    <= meta_ff;
            prev_ff <= q_ff;
        end
    end

    assign q    = q_ff;
    assign rise = q_ff & ~prev_ff;

endmodule : mds_sync

/* File: verilog/mds_top.sv */
/*
 * Multichip sync: input FIFO, clock-phase alignment to the sync pulse
 * clock, lock status, frame-strobe FIFO reset, AXI4-Lite registers, IRQ.
 * Assumes the clock, frame and data pins are asynchronous to MCLK and much slower than it.
 */
// Operation
// - Writing 0xc8 to sync control selects data-rate periodic sync
// - Writing 0x88 to sync control selects FIFO-rate periodic sync
// - Status bit 6 high only while phase is locked to sync clock
// - Frame high over one full input clock period resets the FIFO
// - Outputs of synchronized devices update within one sample clock
// - Delay field bits 1:0 select one of four sampling delays
// - FIFO is eight deep; FIFO rate is data rate over eight
// - With clock multiplier only data-rate sync; direct clock allows both
`timescale 1ns/1ps
module mds_top (
    input  wire logic                      MCLK,
    input  wire logic                      NRST,
    input  wire logic                      INPUT_DATA_CLOCK,
    input  wire logic                      SYNC_PULSE_CLOCK,
    input  wire logic                      FRAME,
    input  wire logic [mds_pkg::DATA_W-1:0] DATA_IN,
    output logic      [mds_pkg::DATA_W-1:0] DAC_DATA,
    output logic                           SYNC_LOCKED,
    output logic                           IRQ,
    input  wire logic [mds_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic                      S_AXI_AWVALID,
    output logic                           S_AXI_AWREADY,
    input  wire logic [31:0]               S_AXI_WDATA,
    input  wire logic [3:0]                S_AXI_WSTRB,
    input  wire logic                      S_AXI_WVALID,
    output logic                           S_AXI_WREADY,
    output logic [1:0]                     S_AXI_BRESP,
    output logic                           S_AXI_BVALID,
    input  wire logic                      S_AXI_BREADY,
    input  wire logic [mds_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic                      S_AXI_ARVALID,
    output logic                           S_AXI_ARREADY,
    output logic [31:0]                    S_AXI_RDATA,
    output logic [1:0]                     S_AXI_RRESP,
    output logic                           S_AXI_RVALID,
    input  wire logic                      S_AXI_RREADY
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0]                 pin_q;
    logic [2:0]                 pin_rise;
    logic [mds_pkg::DATA_W-1:0] data_q;

    mds_sync #(.W(3)) u_pins (
        .clk  (MCLK),
        .rst_n(NRST),
        .d    ({FRAME, SYNC_PULSE_CLOCK, INPUT_DATA_CLOCK}),
        .q    (pin_q),
        .rise (pin_rise)
    );
    mds_sync #(.W(mds_pkg::DATA_W)) u_data (
        .clk  (MCLK),
        .rst_n(NRST),
        .d    (DATA_IN),
        .q    (data_q),
        .rise ()
    );

    logic dci_rise;
    logic sync_rise;
    logic frame_q;
    assign dci_rise  = pin_rise[0];
    assign sync_rise = pin_rise[1];
    assign frame_q   = pin_q[2];

    // ------------------------------------------------------------
    // Registers and mode decode
    // ------------------------------------------------------------
    logic [7:0]               ctrl_ff;
    logic [1:0]               dly_ff;
    logic                     mult_ff;
    logic [mds_pkg::IRQ_W-1:0] irq_stat_ff;
    logic [mds_pkg::IRQ_W-1:0] irq_mask_ff;
    logic                     eff_en;
    logic                     eff_drate;

    assign eff_en    = ctrl_ff[mds_pkg::CTRL_EN_BIT] & ctrl_ff[mds_pkg::CTRL_PER_BIT];
    // Multiplier clocking has no FIFO-rate option, so it falls back
    assign eff_drate = ctrl_ff[mds_pkg::CTRL_DRATE_BIT] | mult_ff;

    // ------------------------------------------------------------
    // Sampling delay and FIFO write
    // ------------------------------------------------------------
    logic [mds_pkg::DLY_TAPS-1:0] dly_sr_ff;
    logic                         sample_tick;
    logic [mds_pkg::DATA_W-1:0]   mem [mds_pkg::FIFO_DEPTH];
    logic [mds_pkg::PTR_W-1:0]    wr_ptr_ff;
    logic [mds_pkg::PTR_W-1:0]    rd_ptr_ff;
    logic                         frame_hi_ff;
    logic                         fifo_rst;
    logic                         realign;

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            dly_sr_ff <= '0;
        end else begin
            dly_sr_ff <= {dly_sr_ff[mds_pkg::DLY_TAPS-2:0], dci_rise};
        end
    end
    assign sample_tick = dly_sr_ff[dly_ff];

    // A strobe over one full period is seen at one tick; a held one fires once
    assign fifo_rst = sample_tick & frame_q & ~frame_hi_ff;

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            frame_hi_ff <= 1'b0;
        end else if (sample_tick) begin
            frame_hi_ff <= frame_q;
        end
    end

    always_ff @(posedge MCLK) begin
        if (sample_tick) begin
            mem[wr_ptr_ff] <= data_q;
        end
    end

    // ------------------------------------------------------------
    // Clock generation phase and lock
    // ------------------------------------------------------------
    logic [mds_pkg::PTR_W-1:0] phase_ff;
    mds_pkg::mds_lock_t        lock_st_ff;
    logic [1:0]                good_cnt_ff;
    logic                      edge_good;
    logic                      lock_ff;
    logic                      ctrl_wr;

    // FIFO-rate edges must land on a wrap of the eight-deep phase
    assign edge_good = eff_drate | (phase_ff == '0);
    // Data-rate mode re-centres the read side on every sync edge
    assign realign   = eff_en & sync_rise & (eff_drate | ~edge_good);

    always_ff @(posedge MCLK) begin
        if (!NRST || fifo_rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= mds_pkg::RD_OFFSET;
        end else if (realign && sample_tick) begin
            // Keep the word written on this tick
            wr_ptr_ff <= wr_ptr_ff + 3'h1;
            rd_ptr_ff <= wr_ptr_ff + 3'h1 - mds_pkg::RD_OFFSET;
        end else if (realign) begin
            rd_ptr_ff <= wr_ptr_ff - mds_pkg::RD_OFFSET;
        end else if (sample_tick) begin
            wr_ptr_ff <= wr_ptr_ff + 3'h1;
            rd_ptr_ff <= rd_ptr_ff + 3'h1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST || realign) begin
            phase_ff <= '0;
        end else if (sample_tick) begin
            phase_ff <= phase_ff + 3'h1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST || ctrl_wr || !eff_en) begin
            lock_st_ff  <= mds_pkg::ST_OFF;
            good_cnt_ff <= '0;
        end else if (sync_rise) begin
            unique case (lock_st_ff)
                mds_pkg::ST_OFF: begin
                    lock_st_ff  <= mds_pkg::ST_ACQ;
                    good_cnt_ff <= '0;
                end
                mds_pkg::ST_ACQ: begin
                    good_cnt_ff <= edge_good ? good_cnt_ff + 2'h1 : 2'h0;
                    if (edge_good && good_cnt_ff + 2'h1 == mds_pkg::LOCK_EDGES) begin
                        lock_st_ff <= mds_pkg::ST_LOCK;
                    end
                end
                mds_pkg::ST_LOCK: begin
                    if (!edge_good) begin
                        lock_st_ff  <= mds_pkg::ST_ACQ;
                        good_cnt_ff <= '0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            lock_ff <= 1'b0;
        end else begin
            // A mode write drops the bit at once, not one cycle late
            lock_ff <= (lock_st_ff == mds_pkg::ST_LOCK) && !ctrl_wr;
        end
    end
    assign SYNC_LOCKED = lock_ff;

    // ------------------------------------------------------------
    // FIFO read and output word
    // ------------------------------------------------------------
    // Read on the same tick as write: a fixed latency keeps devices aligned
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            DAC_DATA <= '0;
        end else if (sample_tick) begin
            DAC_DATA <= mem[rd_ptr_ff];
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic                      aw_got_ff;
    logic                      w_got_ff;
    logic [7:0]                aw_idx_ff;
    logic [31:0]               wdata_ff;
    logic                      wstrb0_ff;
    logic                      wr_do;
    logic [mds_pkg::IRQ_W-1:0] irq_set;
    logic [mds_pkg::IRQ_W-1:0] irq_clr;

    assign S_AXI_AWREADY = ~aw_got_ff;
    assign S_AXI_WREADY  = ~w_got_ff;
    assign wr_do   = aw_got_ff & w_got_ff & ~S_AXI_BVALID;
    assign ctrl_wr = wr_do & wstrb0_ff & (aw_idx_ff == mds_pkg::IDX_SYNC_CTRL);

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            aw_got_ff    <= 1'b0;
            w_got_ff     <= 1'b0;
            aw_idx_ff    <= '0;
            wdata_ff     <= '0;
            wstrb0_ff    <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= mds_pkg::RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && !aw_got_ff) begin
                aw_got_ff <= 1'b1;
                aw_idx_ff <= S_AXI_AWADDR[9:2];
            end
            if (S_AXI_WVALID && !w_got_ff) begin
                w_got_ff  <= 1'b1;
                wdata_ff  <= S_AXI_WDATA;
                wstrb0_ff <= S_AXI_WSTRB[0];
            end
            if (wr_do) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= (aw_idx_ff == mds_pkg::IDX_SYNC_CTRL ||
                                 aw_idx_ff == mds_pkg::IDX_SYNC_STAT ||
                                 aw_idx_ff == mds_pkg::IDX_CLK_DLY   ||
                                 aw_idx_ff == mds_pkg::IDX_IRQ_STAT  ||
                                 aw_idx_ff == mds_pkg::IDX_IRQ_MASK  ||
                                 aw_idx_ff == mds_pkg::IDX_CLK_CFG) ?
                                mds_pkg::RESP_OKAY : mds_pkg::RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
                aw_got_ff    <= 1'b0;
                w_got_ff     <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            ctrl_ff     <= mds_pkg::CTRL_RESET;
            dly_ff      <= mds_pkg::DLY_RESET;
            mult_ff     <= 1'b0;
            irq_mask_ff <= mds_pkg::IRQ_RESET;
        end else if (wr_do && wstrb0_ff) begin
            unique case (aw_idx_ff)
                mds_pkg::IDX_SYNC_CTRL: ctrl_ff     <= wdata_ff[7:0];
                mds_pkg::IDX_CLK_DLY:   dly_ff      <= wdata_ff[1:0];
                mds_pkg::IDX_CLK_CFG:   mult_ff     <= wdata_ff[mds_pkg::CFG_MULT_BIT];
                mds_pkg::IDX_IRQ_MASK:  irq_mask_ff <= wdata_ff[mds_pkg::IRQ_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Interrupt status: write one to clear, a same-cycle event wins
    assign irq_set = {fifo_rst,
                      lock_ff & ((lock_st_ff != mds_pkg::ST_LOCK) | ctrl_wr),
                      ~lock_ff & (lock_st_ff == mds_pkg::ST_LOCK) & ~ctrl_wr};
    assign irq_clr = (wr_do && wstrb0_ff && aw_idx_ff == mds_pkg::IDX_IRQ_STAT) ?
                     wdata_ff[mds_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            irq_stat_ff <= mds_pkg::IRQ_RESET;
            IRQ         <= 1'b0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
            IRQ         <= |(((irq_stat_ff & ~irq_clr) | irq_set) & irq_mask_ff);
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= '0;
            S_AXI_RRESP   <= mds_pkg::RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RRESP   <= mds_pkg::RESP_OKAY;
            unique case (S_AXI_ARADDR[9:2])
                mds_pkg::IDX_SYNC_CTRL: S_AXI_RDATA <= {24'h0, ctrl_ff};
                mds_pkg::IDX_SYNC_STAT: S_AXI_RDATA <= {25'h0, lock_ff, 6'h0};
                mds_pkg::IDX_CLK_DLY:   S_AXI_RDATA <= {30'h0, dly_ff};
                mds_pkg::IDX_IRQ_STAT:  S_AXI_RDATA <= {29'h0, irq_stat_ff};
                mds_pkg::IDX_IRQ_MASK:  S_AXI_RDATA <= {29'h0, irq_mask_ff};
                mds_pkg::IDX_CLK_CFG:   S_AXI_RDATA <= {31'h0, mult_ff};
                default: begin
                    S_AXI_RDATA <= '0;
                    S_AXI_RRESP <= mds_pkg::RESP_SLVERR;
                end
            endcase
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID  <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);

    sequence s_frame_start;
        sample_tick && frame_q && !frame_hi_ff;
    endsequence
    sequence s_fifo_cleared;
        wr_ptr_ff == '0 && rd_ptr_ff == mds_pkg::RD_OFFSET;
    endsequence

    a_ctrl_data_rate: assert property (
        ctrl_wr && wdata_ff[7:0] == mds_pkg::MODE_DATA_RATE |=> eff_en && eff_drate)
        else $error("Data-rate code did not select data-rate sync");
    a_ctrl_fifo_rate: assert property (
        ctrl_wr && wdata_ff[7:0] == mds_pkg::MODE_FIFO_RATE && !mult_ff
        |=> eff_en && !eff_drate)
        else $error("FIFO-rate code did not select FIFO-rate sync");
    a_lock_status_bit: assert property (
        SYNC_LOCKED |-> eff_en && $past(lock_st_ff == mds_pkg::ST_LOCK))
        else $error("Lock shown without a held phase lock");
    a_lock_needs_edges: assert property (
        $rose(SYNC_LOCKED) |-> $past(sync_rise, 2))
        else $error("Lock rose without a sync edge");
    a_frame_fifo_reset: assert property (
        s_frame_start |=> s_fifo_cleared)
        else $error("Frame strobe did not reset FIFO pointers");
    a_frame_held_once: assert property (
        sample_tick && frame_q && frame_hi_ff |-> !fifo_rst)
        else $error("FIFO reset again under a held frame strobe");
    a_out_on_tick: assert property (
        $changed(DAC_DATA) |-> $past(sample_tick))
        else $error("Output word changed off the sampling tick");
    a_delay_three: assert property (
        (dly_ff == 2'h3 && dci_rise) ##1 (dly_ff == 2'h3)[*3] |=> sample_tick)
        else $error("Delay setting three not honoured");
    a_fifo_wrap_eight: assert property (
        eff_en && !eff_drate && sync_rise && phase_ff != '0 |=> phase_ff == '0)
        else $error("FIFO-rate edge off the eight-deep phase not realigned");
    a_mult_drate_only: assert property (
        mult_ff && ctrl_wr && wdata_ff[7:0] == mds_pkg::MODE_FIFO_RATE |=> eff_drate)
        else $error("FIFO-rate mode allowed with clock multiplier");

endmodule : mds_top

/* File: bench/mds_far_model.sv */
/*
 * Far-side model: data source with input clock, words, frame strobe, and
 * a free-running sync pulse clock. Assumes the bench clock edges are at 5+10k ns.
 */
`timescale 1ns/1ps
module mds_far_model (
    output logic        data_clk,
    output logic        sync_clk,
    output logic        frame,
    output logic [15:0] data
);
    // ------------------------------------------------------------
    // Clocks and stream
    // ------------------------------------------------------------
    initial begin
        data_clk = 1'b0;
        sync_clk = 1'b0;
        frame    = 1'b0;
        data     = 16'h0000;
    end
    // 20 ns input clock, sync at 160 ns: a legal rate for both modes
    initial begin
        #3;
        forever #10 data_clk = ~data_clk;
    end
    initial begin
        #3;
        forever #80 sync_clk = ~sync_clk;
    end
    // Word changes on the falling edge, stable around each rise
    always @(negedge data_clk) data <= data + 16'h0001;
    // Strobe held over n whole input clock periods
    task strobe(input int n);
        @(negedge data_clk);
        frame = 1'b1;
        repeat (n) @(negedge data_clk);
        frame = 1'b0;
    endtask : strobe
endmodule : mds_far_model

/* File: bench/test_multichip_dac_sync.sv */
/*
 * Bench: AXI4-Lite register tasks and sync sequences, self-checking.
 * Assumes mds_top and mds_far_model; byte address is four times the index.
 */
`timescale 1ns/1ps
module test_multichip_dac_sync;
    logic        mclk, nrst, awv, wv, bre, arv, rre, sl, irq, awr, wr, bv, arr, rv;
    logic [11:0] awa, ara;
    logic [31:0] wd, rd, v;
    logic [3:0]  ws;
    logic [1:0]  br, rr;
    logic [15:0] dout, din, d0;
    logic        dck, sck, frm, a;
    int          err_count, tests_run;

    mds_far_model u_far (.data_clk(dck), .sync_clk(sck), .frame(frm), .data(din));
    mds_top u_dut (.MCLK(mclk), .NRST(nrst), .INPUT_DATA_CLOCK(dck), .SYNC_PULSE_CLOCK(sck),
        .FRAME(frm), .DATA_IN(din), .DAC_DATA(dout), .SYNC_LOCKED(sl), .IRQ(irq),
        .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rre));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task results;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task hang;
        err_count++;
        $display("[ERR] %0t no answer", $time);
        results();
    endtask : hang
    // Both channels offered together, each dropped when taken
    task axi_wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] st,
                input logic [1:0] er);
        int n;
        @(posedge mclk);
        awa <= {2'h0, idx, 2'h0};
        awv <= 1'b1;
        wd  <= d;
        ws  <= st;
        wv  <= 1'b1;
        bre <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
            if (bv) break;
        end
        if (n == 50) hang();
        bre <= 1'b0;
        chk({30'h0, br}, {30'h0, er});
    endtask : axi_wr
    task axi_rd(input logic [7:0] idx, input logic [1:0] er, output logic [31:0] q);
        int n;
        @(posedge mclk);
        ara <= {2'h0, idx, 2'h0};
        arv <= 1'b1;
        rre <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (arv && arr) arv <= 1'b0;
            if (rv) break;
        end
        if (n == 50) hang();
        q = rd;
        rre <= 1'b0;
        chk({30'h0, rr}, {30'h0, er});
    endtask : axi_rd
    task wait_lock(input logic e);
        int n;
        for (n = 0; n < 400 && sl !== e; n++) @(posedge mclk);
        if (n == 400) hang();
    endtask : wait_lock

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        {nrst, awv, wv, bre, arv, rre} = 6'h00;
        {awa, ara, wd, ws} = 60'h0;
        err_count = 0;
        tests_run = 0;
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        chk({30'h0, sl, irq}, 32'h0);
        axi_rd(mds_pkg::IDX_SYNC_CTRL, 2'h0, v);
        chk(v, 32'h0);
        axi_rd(mds_pkg::IDX_SYNC_STAT, 2'h0, v);
        chk(v, 32'h0);
        axi_rd(mds_pkg::IDX_IRQ_STAT, 2'h0, v);
        chk(v, 32'h0);
        axi_rd(8'h30, mds_pkg::RESP_SLVERR, v);
        chk(v, 32'h0);
        axi_wr(8'h30, 32'hc8, 4'hf, mds_pkg::RESP_SLVERR);
        for (int i = 0; i < 4; i++) begin
            axi_wr(mds_pkg::IDX_CLK_DLY, i, 4'hf, 2'h0);
            axi_rd(mds_pkg::IDX_CLK_DLY, 2'h0, v);
            chk(v, i);
        end
        axi_wr(mds_pkg::IDX_SYNC_CTRL, 32'hc8, 4'h0, 2'h0);
        axi_rd(mds_pkg::IDX_SYNC_CTRL, 2'h0, v);
        chk(v, 32'h0);
        axi_wr(mds_pkg::IDX_SYNC_CTRL, 32'hc8, 4'hf, 2'h0);
        axi_rd(mds_pkg::IDX_SYNC_CTRL, 2'h0, v);
        chk(v, 32'hc8);
        wait_lock(1'b1);
        axi_rd(mds_pkg::IDX_SYNC_STAT, 2'h0, v);
        chk(v, 32'h40);
        axi_rd(mds_pkg::IDX_IRQ_STAT, 2'h0, v);
        chk(v, 32'h1);
        axi_wr(mds_pkg::IDX_IRQ_MASK, 32'h0, 4'hf, 2'h0);
        repeat (2) @(posedge mclk);
        a = irq;
        axi_wr(mds_pkg::IDX_IRQ_MASK, 32'h7, 4'hf, 2'h0);
        repeat (2) @(posedge mclk);
        chk({30'h0, a, irq}, 32'h1);
        axi_wr(mds_pkg::IDX_IRQ_STAT, 32'h7, 4'hf, 2'h0);
        axi_rd(mds_pkg::IDX_IRQ_STAT, 2'h0, v);
        chk(v, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // One full input clock period is enough to reset
        u_far.strobe(1);
        repeat (20) @(posedge mclk);
        axi_rd(mds_pkg::IDX_IRQ_STAT, 2'h0, v);
        chk(v, 32'h4);
        axi_wr(mds_pkg::IDX_IRQ_STAT, 32'h4, 4'hf, 2'h0);
        u_far.strobe(2);
        repeat (20) @(posedge mclk);
        axi_rd(mds_pkg::IDX_IRQ_STAT, 2'h0, v);
        chk(v, 32'h4);
        d0 = dout;
        repeat (16) @(posedge mclk);
        chk({16'h0, dout - d0}, 32'h8);
        axi_wr(mds_pkg::IDX_SYNC_CTRL, 32'h88, 4'hf, 2'h0);
        chk({31'h0, sl}, 32'h0);
        wait_lock(1'b1);
        axi_rd(mds_pkg::IDX_SYNC_STAT, 2'h0, v);
        chk(v, 32'h40);
        // Multiplier clocking turns a FIFO-rate request into data-rate sync
        axi_wr(mds_pkg::IDX_CLK_CFG, 32'h1, 4'hf, 2'h0);
        axi_wr(mds_pkg::IDX_SYNC_CTRL, 32'h88, 4'hf, 2'h0);
        wait_lock(1'b1);
        axi_rd(mds_pkg::IDX_CLK_CFG, 2'h0, v);
        chk(v, 32'h1);
        axi_wr(mds_pkg::IDX_SYNC_CTRL, 32'h0, 4'hf, 2'h0);
        wait_lock(1'b0);
        axi_rd(mds_pkg::IDX_SYNC_STAT, 2'h0, v);
        chk(v, 32'h0);
        results();
    end
endmodule : test_multichip_dac_sync
